// ==== fdcrc_map.svh ====
`ifndef FDCRC_MAP_SVH
`define FDCRC_MAP_SVH

// Register byte offsets on the AXI4-Lite slave.
`define FDCRC_OFS_DOR 8'h00
`define FDCRC_OFS_CCR 8'h04
`define FDCRC_OFS_DSR 8'h08
`define FDCRC_OFS_DIR 8'h0C
`define FDCRC_OFS_MODE 8'h10
`define FDCRC_OFS_STAT 8'h14
`define FDCRC_OFS_SEP 8'h18

// Digital output register fields.
`define FDCRC_DOR_RESET 0
`define FDCRC_DOR_DMA_GATE_ENABLE 1

// Configuration control register fields.
`define FDCRC_CCR_RATE_LO 0
`define FDCRC_CCR_PREOFF 2

// Rate select register fields.
`define FDCRC_DSR_DLY_LO 2
`define FDCRC_DSR_PWRDN 6
`define FDCRC_DSR_SWRST 7

// Mode register fields.
`define FDCRC_MODE_LO 0
`define FDCRC_MODE_LOCK 2
`define FDCRC_MODE_DMAEN 3
`define FDCRC_MODE_NOPOLL 4

// Reset values and codes.
`define FDCRC_RATE_RST 2'h2
`define FDCRC_RATE_500K 2'h0
`define FDCRC_RATE_1M 2'h3
`define FDCRC_DLY_DEFAULT 3'h0
`define FDCRC_DLY_OFF 3'h7

// Precompensation timing.
`define FDCRC_CLK_PERIOD_PS 25000
`define FDCRC_STEP_PS 41670
`define FDCRC_STEP_CYC (((`FDCRC_STEP_PS / `FDCRC_CLK_PERIOD_PS) < 1) ? 1 : (`FDCRC_STEP_PS / `FDCRC_CLK_PERIOD_PS))
`define FDCRC_DEF_STEPS_FAST 3'h1
`define FDCRC_DEF_STEPS_SLOW 3'h3
`define FDCRC_SR_LEN 13
`define FDCRC_SR_CENTER 6

// Data separator lock time in bit times.
`define FDCRC_LOCK_BITS 64

`endif

// ==== fdcrc_pkg.sv ====
package fdcrc_pkg;

  typedef enum logic [1:0] {
    MODE_AT,
    MODE_PS2,
    MODE_ALT
  } fdcrc_mode_e;

  typedef enum logic [1:0] {
    CORE_RESET,
    CORE_IDLE,
    CORE_POLL
  } fdcrc_core_e;

  typedef struct packed {
    logic [7:0] clock_byte;
    logic [7:0] data_byte;
  } fdcrc_sep_s;

endpackage : fdcrc_pkg

// ==== fdcrc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fdcrc_map.svh"

module fdcrc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic buffer_polarity_strap,
  input wire logic drive_type_strap,
  input wire logic disk_change_pin,
  input wire logic read_data_in,
  input wire logic data_window,
  input wire logic wr_cell_stb,
  input wire logic wr_cell_bit,
  input wire logic xfer_active,
  input wire logic dma_acknowledge_n,
  input wire logic fifo_host_sel,
  output logic write_data_out,
  output logic density_select_out,
  output logic dma_request,
  output logic fifo_select,
  output logic fifo_clear,
  output logic core_reset,
  output logic poll_active,
  output logic sep_locked,
  output logic sep_byte_stb
);

  localparam int SR_LEN = `FDCRC_SR_LEN;
  localparam int CENTER = `FDCRC_SR_CENTER;
  localparam int STEP_CYC = `FDCRC_STEP_CYC;

  logic hw_rst;
  assign hw_rst = !aresetn;

  // Register state.
  logic dor_reset_ff;
  logic dma_gate_enable_ff;
  logic [1:0] rate_ff;
  logic delay_field_a_off_flag_ff;
  logic [2:0] delay_field_a_ff;
  logic power_down_ff;
  logic dsr_reset_ff;
  fdcrc_pkg::fdcrc_mode_e mode_ff;
  logic lock_ff;
  logic dma_enable_ff;
  logic no_poll_ff;
  logic ident_ff;
  logic ident_take_ff;
  fdcrc_pkg::fdcrc_core_e core_ff;
  fdcrc_pkg::fdcrc_sep_s sep_ff;

  // AXI4-Lite slave state.
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic wr_lane0;
  logic wr_hit;

  assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_lane0 = wr_go && wstrb_ff[0];

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_comb begin
    case (awaddr_ff)
      `FDCRC_OFS_DOR, `FDCRC_OFS_CCR, `FDCRC_OFS_DSR, `FDCRC_OFS_MODE: wr_hit = 1'b1;
      `FDCRC_OFS_DIR, `FDCRC_OFS_STAT, `FDCRC_OFS_SEP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A software reset that lands in the same cycle as a pin reset is swallowed by the pin reset.
  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      dor_reset_ff <= 1'b1;
      dma_gate_enable_ff <= 1'b0;
    end else if (wr_lane0 && awaddr_ff == `FDCRC_OFS_DOR) begin
      dor_reset_ff <= wdata_ff[`FDCRC_DOR_RESET];
      dma_gate_enable_ff <= wdata_ff[`FDCRC_DOR_DMA_GATE_ENABLE];
    end
  end

  // Rate, delay and delay_field_a-off fields are touched only by writes and the pin reset.
  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      rate_ff <= `FDCRC_RATE_RST;
      delay_field_a_off_flag_ff <= 1'b0;
      delay_field_a_ff <= `FDCRC_DLY_DEFAULT;
    end else if (wr_lane0 && awaddr_ff == `FDCRC_OFS_CCR) begin
      rate_ff <= wdata_ff[`FDCRC_CCR_RATE_LO +: 2];
      if (mode_ff == fdcrc_pkg::MODE_ALT) begin
        delay_field_a_off_flag_ff <= wdata_ff[`FDCRC_CCR_PREOFF];
      end
    end else if (wr_lane0 && awaddr_ff == `FDCRC_OFS_DSR) begin
      rate_ff <= wdata_ff[`FDCRC_CCR_RATE_LO +: 2];
      delay_field_a_ff <= wdata_ff[`FDCRC_DSR_DLY_LO +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      dsr_reset_ff <= 1'b0;
      power_down_ff <= 1'b0;
    end else begin
      dsr_reset_ff <= wr_lane0 && awaddr_ff == `FDCRC_OFS_DSR && wdata_ff[`FDCRC_DSR_SWRST];
      if (dor_reset_ff || dsr_reset_ff) begin
        power_down_ff <= 1'b0;
      end else if (wr_lane0 && awaddr_ff == `FDCRC_OFS_DSR) begin
        power_down_ff <= wdata_ff[`FDCRC_DSR_PWRDN];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      mode_ff <= fdcrc_pkg::MODE_AT;
      lock_ff <= 1'b0;
      no_poll_ff <= 1'b0;
    end else if (wr_lane0 && awaddr_ff == `FDCRC_OFS_MODE) begin
      case (wdata_ff[`FDCRC_MODE_LO +: 2])
        2'h1: mode_ff <= fdcrc_pkg::MODE_PS2;
        2'h2: mode_ff <= fdcrc_pkg::MODE_ALT;
        default: mode_ff <= fdcrc_pkg::MODE_AT;
      endcase
      lock_ff <= wdata_ff[`FDCRC_MODE_LOCK];
      no_poll_ff <= wdata_ff[`FDCRC_MODE_NOPOLL];
    end
  end

  // The DMA enable survives the reset pin; only power-on clears it.
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      dma_enable_ff <= 1'b0;
    end else if (wr_lane0 && awaddr_ff == `FDCRC_OFS_MODE) begin
      dma_enable_ff <= wdata_ff[`FDCRC_MODE_DMAEN];
    end
  end

  // The drive-type strap is caught on the first edge after the pin reset releases.
  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      ident_take_ff <= 1'b1;
      ident_ff <= 1'b0;
    end else if (ident_take_ff) begin
      ident_take_ff <= 1'b0;
      ident_ff <= drive_type_strap;
    end
  end

  logic any_reset;
  assign any_reset = dor_reset_ff || dsr_reset_ff;

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      core_ff <= fdcrc_pkg::CORE_RESET;
    end else begin
      case (core_ff)
        fdcrc_pkg::CORE_RESET: begin
          if (!any_reset) begin
            core_ff <= no_poll_ff ? fdcrc_pkg::CORE_IDLE : fdcrc_pkg::CORE_POLL;
          end
        end
        fdcrc_pkg::CORE_IDLE, fdcrc_pkg::CORE_POLL: begin
          if (any_reset) begin
            core_ff <= fdcrc_pkg::CORE_RESET;
          end else begin
            core_ff <= no_poll_ff ? fdcrc_pkg::CORE_IDLE : fdcrc_pkg::CORE_POLL;
          end
        end
        default: core_ff <= fdcrc_pkg::CORE_RESET;
      endcase
    end
  end

  logic running;
  assign running = core_ff != fdcrc_pkg::CORE_RESET && !any_reset && !power_down_ff;

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      core_reset <= 1'b1;
      fifo_clear <= 1'b1;
      poll_active <= 1'b0;
      dma_request <= 1'b0;
      fifo_select <= 1'b0;
    end else begin
      core_reset <= any_reset;
      fifo_clear <= any_reset && !lock_ff;
      poll_active <= core_ff == fdcrc_pkg::CORE_POLL && running;
      dma_request <= dma_enable_ff && xfer_active && running;
      fifo_select <= !dma_acknowledge_n || fifo_host_sel;
    end
  end

  // Drive interface polarity: strap low means the pins are active low, except density select, which is then active high.
  logic drv_inv;
  logic disk_change_flag;
  logic rd_pulse;
  logic high_rate;
  assign drv_inv = !buffer_polarity_strap;
  assign disk_change_flag = disk_change_pin ^ drv_inv;
  assign rd_pulse = read_data_in ^ drv_inv;
  assign high_rate = rate_ff == `FDCRC_RATE_500K || rate_ff == `FDCRC_RATE_1M;

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      density_select_out <= drv_inv;
    end else begin
      density_select_out <= (ident_ff ? high_rate : !high_rate) ^ !drv_inv;
    end
  end

  // Data separator back end: the analog loop supplies the window.
  logic win_d_ff;
  logic seen_ff;
  logic [2:0] dcnt_ff;
  logic [7:0] csr_ff;
  logic [7:0] dsr_sh_ff;
  logic [6:0] lock_cnt_ff;
  logic win_edge;
  assign win_edge = win_d_ff != data_window;

  always_ff @(posedge aclk) begin
    if (hw_rst || !running) begin
      win_d_ff <= 1'b0;
      seen_ff <= 1'b0;
      dcnt_ff <= 3'h0;
      csr_ff <= 8'h00;
      dsr_sh_ff <= 8'h00;
      sep_ff <= '0;
      sep_byte_stb <= 1'b0;
    end else begin
      win_d_ff <= data_window;
      sep_byte_stb <= 1'b0;
      if (win_edge) begin
        seen_ff <= rd_pulse;
        if (win_d_ff) begin
          dsr_sh_ff <= {dsr_sh_ff[6:0], seen_ff || rd_pulse};
          dcnt_ff <= dcnt_ff + 3'h1;
          if (dcnt_ff == 3'h7) begin
            sep_ff.data_byte <= {dsr_sh_ff[6:0], seen_ff || rd_pulse};
            sep_ff.clock_byte <= csr_ff;
            sep_byte_stb <= 1'b1;
          end
        end else begin
          csr_ff <= {csr_ff[6:0], seen_ff || rd_pulse};
        end
      end else if (rd_pulse) begin
        seen_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (hw_rst || !running) begin
      lock_cnt_ff <= 7'h00;
      sep_locked <= 1'b0;
    end else if (win_edge && win_d_ff && !sep_locked) begin
      lock_cnt_ff <= lock_cnt_ff + 7'h01;
      sep_locked <= lock_cnt_ff == 7'(`FDCRC_LOCK_BITS - 1);
    end
  end

  // Write precompensation. Cells enter two positions deep so each bit sees both neighbours.
  logic [4:0] cell_ff;
  logic is_early;
  logic is_late;
  logic [2:0] steps;
  logic [SR_LEN-1:0] early_sr_ff;
  logic [SR_LEN-1:0] late_sr_ff;
  logic [SR_LEN-1:0] nom_sr_ff;
  logic early_tap;
  logic late_tap;
  logic pulse_in;

  always_ff @(posedge aclk) begin
    if (hw_rst || !running) begin
      cell_ff <= 5'h00;
    end else if (wr_cell_stb) begin
      cell_ff <= {cell_ff[3:0], wr_cell_bit};
    end
  end

  // Neighbour two cells behind pushes the bit late, two ahead pulls it early.
  assign is_late = cell_ff[4] && !cell_ff[0];
  assign is_early = cell_ff[0] && !cell_ff[4];
  assign pulse_in = wr_cell_stb && cell_ff[2] && running;

  always_comb begin
    case (delay_field_a_ff)
      `FDCRC_DLY_OFF: steps = 3'h0;
      `FDCRC_DLY_DEFAULT: steps = (rate_ff == `FDCRC_RATE_1M) ? `FDCRC_DEF_STEPS_FAST : `FDCRC_DEF_STEPS_SLOW;
      default: steps = delay_field_a_ff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (hw_rst || !running) begin
      early_sr_ff <= '0;
      late_sr_ff <= '0;
      nom_sr_ff <= '0;
    end else begin
      early_sr_ff <= {early_sr_ff[SR_LEN-2:0], pulse_in && is_early};
      late_sr_ff <= {late_sr_ff[SR_LEN-2:0], pulse_in && is_late};
      nom_sr_ff <= {nom_sr_ff[SR_LEN-2:0], pulse_in && !is_early && !is_late};
    end
  end

  // Step count beyond the shifter's reach saturates at the end taps.
  always_comb begin
    early_tap = early_sr_ff[CENTER];
    late_tap = late_sr_ff[CENTER];
    for (int i = 1; i <= CENTER; i++) begin
      if (int'(steps) * STEP_CYC == i) begin
        early_tap = early_sr_ff[CENTER - i];
        late_tap = late_sr_ff[CENTER + i];
      end else if (int'(steps) * STEP_CYC > CENTER && i == CENTER) begin
        early_tap = early_sr_ff[0];
        late_tap = late_sr_ff[SR_LEN-1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      write_data_out <= drv_inv;
    end else begin
      write_data_out <= (early_tap || late_tap || nom_sr_ff[CENTER]) ^ drv_inv;
    end
  end

  // Read side.
  logic [7:0] dir_val;
  always_comb begin
    case (mode_ff)
      fdcrc_pkg::MODE_ALT: dir_val = {!disk_change_flag, 3'h0, dma_gate_enable_ff, delay_field_a_off_flag_ff, rate_ff};
      fdcrc_pkg::MODE_PS2: dir_val = {disk_change_flag, 4'hF, rate_ff, !high_rate};
      default: dir_val = {disk_change_flag, 7'h00};
    endcase
  end

  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `FDCRC_OFS_DOR: rd_val = {30'h0, dma_gate_enable_ff, dor_reset_ff};
      `FDCRC_OFS_CCR: rd_val = 32'h00000000;
      `FDCRC_OFS_DSR: rd_val = {24'h0, 1'b0, power_down_ff, 1'b0, delay_field_a_ff, rate_ff};
      `FDCRC_OFS_DIR: rd_val = {24'h0, dir_val};
      `FDCRC_OFS_MODE: rd_val = {27'h0, no_poll_ff, dma_enable_ff, lock_ff, mode_ff};
      `FDCRC_OFS_STAT: rd_val = {26'h0, ident_ff, sep_locked, core_ff, dsr_reset_ff, dor_reset_ff};
      `FDCRC_OFS_SEP: rd_val = {16'h0, sep_ff};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (hw_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : fdcrc_top
`default_nettype wire

// ==== fdcrc_chk_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fdcrc_map.svh"
module fdcrc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic buffer_polarity_strap,
  input wire logic wr_cell_stb,
  input wire logic wr_cell_bit,
  input wire logic xfer_active,
  input wire logic dma_acknowledge_n,
  input wire logic write_data_out,
  input wire logic dma_request,
  input wire logic fifo_select,
  input wire logic fifo_clear,
  input wire logic core_reset,
  input wire logic poll_active,
  input wire logic sep_byte_stb
);
  logic [4:0] since_ff;
  logic act;
  // The active level of the write line equals the strap, so one compare covers both polarities.
  assign act = write_data_out == buffer_polarity_strap;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_ff <= 5'h1F;
    end else if (wr_cell_stb) begin
      since_ff <= 5'h00;
    end else if (since_ff != 5'h1F) begin
      since_ff <= since_ff + 5'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  core_held_a: assert property ($rose(aresetn) |-> core_reset)
    else $error("core left reset without host clear");
  fifo_clr_a: assert property (fifo_clear |-> core_reset)
    else $error("fifo clear outside a reset");
  dma_req_a: assert property (dma_request |-> $past(xfer_active))
    else $error("dma request without transfer");
  fifo_sel_a: assert property (!dma_acknowledge_n |=> fifo_select)
    else $error("acknowledge did not select fifo");
  ccr_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `FDCRC_OFS_CCR |=>
    s_axi_rvalid && s_axi_rdata == 32'h0) else $error("write only register read nonzero");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h1C |=>
    s_axi_rvalid && s_axi_rresp == 2'h2) else $error("unmapped read not refused");
  // A pulse launched by a strobe leaves the shifter at most twice the centre offset plus one cycles later.
  delay_field_a_win_a: assert property ($rose(act) |-> since_ff <= 5'h0D)
    else $error("write pulse outside shifter reach");
  idle_pol_a: assert property (since_ff == 5'h1F |-> !act)
    else $error("write line active while idle");
  poll_stop_a: assert property (core_reset |-> ##[0:2] !poll_active)
    else $error("polling during reset");
  byte_stb_a: assert property (sep_byte_stb |=> !sep_byte_stb)
    else $error("byte strobe longer than one cycle");
endmodule : fdcrc_chk
bind fdcrc_top fdcrc_chk i_fdcrc_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .buffer_polarity_strap, .wr_cell_stb, .wr_cell_bit,
  .xfer_active, .dma_acknowledge_n, .write_data_out, .dma_request, .fifo_select, .fifo_clear,
  .core_reset, .poll_active, .sep_byte_stb);
`default_nettype wire

// ==== fdcrc_drv.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdcrc_drv (
  input wire logic aclk,
  input wire logic buffer_polarity_strap,
  input wire logic write_data_out,
  input wire logic dsk_chg,
  input wire logic rd_on,
  output logic disk_change_pin,
  output logic read_data_in,
  output logic data_window,
  output logic [15:0] gap
);
  logic [3:0] cell_ff = 4'h0;
  logic [15:0] cnt_ff = 16'h0;
  logic act_ff = 1'b0;
  logic act;
  assign act = write_data_out == buffer_polarity_strap;
  assign disk_change_pin = dsk_chg ? buffer_polarity_strap : ~buffer_polarity_strap;
  // The window stands still outside a read so the separator cannot lock on nothing.
  assign data_window = rd_on && cell_ff[3];
  always_ff @(posedge aclk) begin
    cell_ff <= rd_on ? cell_ff + 4'h1 : 4'h0;
    read_data_in <= (rd_on && cell_ff == 4'hB) ? buffer_polarity_strap : ~buffer_polarity_strap;
    act_ff <= act;
    if (act && !act_ff) begin
      gap <= cnt_ff;
      cnt_ff <= 16'h1;
    end else begin
      cnt_ff <= cnt_ff + 16'h1;
    end
  end
endmodule : fdcrc_drv
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fdcrc_map.svh"
module testbench;
  logic aclk, aresetn, por_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic buffer_polarity_strap, drive_type_strap, disk_change_pin, read_data_in, data_window;
  logic wr_cell_stb, wr_cell_bit, xfer_active, dma_acknowledge_n, fifo_host_sel, write_data_out;
  logic density_select_out, dma_request, fifo_select, fifo_clear, core_reset, poll_active;
  logic sep_locked, sep_byte_stb, dsk_chg, rd_on, at7;
  logic [15:0] gap;
  logic [7:0] tv [5] = '{8'h1E, 8'h06, 8'h02, 8'h1A, 8'h03};
  logic [15:0] tg [5] = '{16'h0020, 16'h0022, 16'h0026, 16'h002C, 16'h0022};
  int n_fail, num_checks;

  fdcrc_top i_fdcrc_top (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .buffer_polarity_strap, .drive_type_strap, .disk_change_pin, .read_data_in,
    .data_window, .wr_cell_stb, .wr_cell_bit, .xfer_active, .dma_acknowledge_n, .fifo_host_sel,
    .write_data_out, .density_select_out, .dma_request, .fifo_select, .fifo_clear, .core_reset,
    .poll_active, .sep_locked, .sep_byte_stb);
  fdcrc_drv i_fdcrc_drv (.aclk, .buffer_polarity_strap, .write_data_out, .dsk_chg, .rd_on,
    .disk_change_pin, .read_data_in, .data_window, .gap);

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      n_fail++;
      $display("BAD bus answer expected within 200 cycles seen none");
      end_of_test();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      tick(n);
      if (s_axi_awready && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      tick(n);
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      tick(n);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      tick(n);
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rdr

  task automatic wait_for(input string nm, ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) begin
      @(posedge aclk);
    end
    chk(nm, {31'h0, v}, {31'h0, s});
  endtask : wait_for

  // Cells sit 16 cycles apart so that a six step shift never crosses into the next cell.
  // A cell leaves three strobes after it enters, so trailing zero cells flush the last pulse out.
  task automatic cells(input logic [6:0] p);
    for (int i = 6; i >= 0; i--) begin
      wr_cell_stb <= 1'b1;
      wr_cell_bit <= p[i];
      @(posedge aclk);
      wr_cell_stb <= 1'b0;
      repeat (15) @(posedge aclk);
    end
    repeat (20) @(posedge aclk);
  endtask : cells

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, wr_cell_stb, wr_cell_bit} = '0;
    {xfer_active, fifo_host_sel, buffer_polarity_strap, drive_type_strap, dsk_chg, rd_on} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, dma_acknowledge_n} = 3'h7;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    num_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge aclk);
    chk("core_reset", 1, core_reset);
    chk("fifo_clear", 1, fifo_clear);
    rdr(`FDCRC_OFS_STAT);
    chk("stat_dor", 1, rd[0]);
    rdr(8'h1C);
    chk("unmapped", 2, rsp);
    wr(`FDCRC_OFS_CCR, 8'h02);
    rdr(`FDCRC_OFS_CCR);
    chk("ccr_read", 0, rd);
    wr(`FDCRC_OFS_DOR, 8'h00);
    wait_for("core_out", core_reset, 1'b0, 10);
    wait_for("poll", poll_active, 1'b1, 50);
    dsk_chg <= 1'b1;
    rdr(`FDCRC_OFS_DIR);
    at7 = rd[7];
    chk("dir_at", 8'h80, rd[7:0]);
    wr(`FDCRC_OFS_MODE, 8'h0A);
    wr(`FDCRC_OFS_DOR, 8'h02);
    wr(`FDCRC_OFS_CCR, 8'h06);
    rdr(`FDCRC_OFS_DIR);
    chk("dir_alt", {~at7, 7'h0E}, rd[7:0]);
    wr(`FDCRC_OFS_DOR, 8'h00);
    rdr(`FDCRC_OFS_DIR);
    chk("dir_gate", {~at7, 7'h06}, rd[7:0]);
    wr(`FDCRC_OFS_DSR, 8'h8E);
    wait_for("dsr_set", core_reset, 1'b1, 5);
    wait_for("dsr_clear", core_reset, 1'b0, 10);
    rdr(`FDCRC_OFS_STAT);
    chk("stat_rst", 0, rd[1:0]);
    rdr(`FDCRC_OFS_DIR);
    chk("dir_swrst", {~at7, 7'h06}, rd[7:0]);
    wait_for("poll_again", poll_active, 1'b1, 50);
    wr(`FDCRC_OFS_DSR, 8'h42);
    rdr(`FDCRC_OFS_DSR);
    chk("pwrdn_set", 8'h42, rd[7:0]);
    wr(`FDCRC_OFS_DOR, 8'h01);
    rdr(`FDCRC_OFS_DSR);
    chk("pwrdn_exit", 0, rd[6]);
    wr(`FDCRC_OFS_DSR, 8'h8A);
    repeat (4) @(posedge aclk);
    chk("dor_prec", 1, core_reset);
    chk("fifo_unlock", 1, fifo_clear);
    wr(`FDCRC_OFS_MODE, 8'h0E);
    wait_for("fifo_lock", fifo_clear, 1'b0, 10);
    wr(`FDCRC_OFS_DOR, 8'h00);
    xfer_active <= 1'b1;
    wait_for("drq_on", dma_request, 1'b1, 10);
    xfer_active <= 1'b0;
    wait_for("drq_off", dma_request, 1'b0, 10);
    dma_acknowledge_n <= 1'b0;
    wait_for("fifo_sel", fifo_select, 1'b1, 5);
    dma_acknowledge_n <= 1'b1;
    wait_for("fifo_desel", fifo_select, 1'b0, 5);
    for (int i = 0; i < 4; i++) begin
      wr(`FDCRC_OFS_CCR, 8'h04 | 8'(i));
      repeat (2) @(posedge aclk);
      wait_for("density", density_select_out, (i == 0 || i == 3) ? 1'b0 : 1'b1, 10);
    end
    for (int i = 0; i < 5; i++) begin
      wr(`FDCRC_OFS_DSR, tv[i]);
      cells(7'h50);
      chk("delay_field_a_gap", {16'h0, tg[i]}, {16'h0, gap});
    end
    rd_on <= 1'b1;
    wait_for("sep_lock", sep_locked, 1'b1, 1100);
    wait_for("sep_byte", sep_byte_stb, 1'b1, 200);
    rdr(`FDCRC_OFS_SEP);
    chk("sep_bytes", 32'h000000FF, rd);
    rd_on <= 1'b0;
    drive_type_strap <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("core_hw", 1, core_reset);
    rdr(`FDCRC_OFS_MODE);
    chk("mode_keep", 8, rd[4:0]);
    chk("density_ident", 0, density_select_out);
    wr(`FDCRC_OFS_DOR, 8'h00);
    wr(`FDCRC_OFS_MODE, 8'h0A);
    rdr(`FDCRC_OFS_DIR);
    chk("dir_hw", {~at7, 7'h02}, rd[7:0]);
    por_n <= 1'b0;
    @(posedge aclk);
    por_n <= 1'b1;
    @(posedge aclk);
    rdr(`FDCRC_OFS_MODE);
    chk("mode_por", 0, rd[3]);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
